/* File: design/dss_ctrl.sv */
// Purpose: Decides when the battery load switch connects and sleeps.
// Assumes: Inputs are asynchronous pins; clk_i is 20 MHz.
// Notes: Times resolve to one slow tick (1 ms).
`timescale 1ns/1ps
module dss_ctrl
  import dss_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES,
  parameter int unsigned TURN_ON_TICKS = TURN_ON_HOLD_MS,
  parameter int unsigned SLEEP_TICKS = SLEEP_HOLD_MS,
  parameter int unsigned SHUTDOWN_TICKS = SHUTDOWN_DELAY_MS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic hold_button_n_i,
  input wire logic wake_i,
  input wire logic shutdown_req_i,
  output logic switch_on_o,
  output logic discharge_on_o,
  output dss_pkg::dss_state_t state_o
);
  import dss_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // Slow timebase

  logic tick;

  dss_tick_div #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers, two stages on the tick

  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] next_sync_a;
  logic [2:0] next_sync_b;
  logic btn_low;
  logic wake_s;
  logic sdr_s;

  always_comb
  begin
    next_sync_a = sync_a;
    next_sync_b = sync_b;
    if (tick)
    begin
      next_sync_a = {shutdown_req_i, wake_i, ~hold_button_n_i};
      next_sync_b = sync_a;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // Idle levels: button released, wake and shutdown low
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end
    else
    begin
      sync_a <= next_sync_a;
      sync_b <= next_sync_b;
    end
  end

  assign btn_low = sync_b[0];
  assign wake_s = sync_b[1];
  assign sdr_s = sync_b[2];

  //////////////////////////////////////////////////////////////////////////
  // Main state, counters and edge history

  dss_state_t state;
  dss_state_t next_state;
  logic [CNT_W-1:0] hold_cnt;
  logic [CNT_W-1:0] next_hold_cnt;
  logic [CNT_W-1:0] delay_cnt;
  logic [CNT_W-1:0] next_delay_cnt;
  logic wake_d;
  logic next_wake_d;
  logic sdr_armed;
  logic next_sdr_armed;
  logic btn_latch;
  logic next_btn_latch;
  logic press_seen;
  logic next_press_seen;
  logic wake_rise;
  logic sdr_rise;

  // A press that is still held after turn-on must be released first,
  // otherwise a long power-on press would run on into deep sleep.
  always_comb
  begin
    wake_rise = wake_s & ~wake_d;
    sdr_rise = sdr_s & sdr_armed;
    next_state = state;
    next_hold_cnt = hold_cnt;
    next_delay_cnt = delay_cnt;
    next_wake_d = wake_d;
    next_sdr_armed = sdr_armed;
    next_btn_latch = btn_latch;
    next_press_seen = press_seen;
    if (tick)
    begin
      next_wake_d = wake_s;
      if (!sdr_s)
      begin
        next_sdr_armed = 1'b1;
      end
      else if (sdr_rise)
      begin
        next_sdr_armed = 1'b0;
      end
      if (!btn_low)
      begin
        next_hold_cnt = '0;
        next_btn_latch = 1'b0;
      end
      else if (!btn_latch)
      begin
        next_hold_cnt = hold_cnt + 1'b1;
      end
      case (state)
        DSS_OFF:
        begin
          if (btn_low && !btn_latch)
          begin
            if (hold_cnt == CNT_W'(TURN_ON_TICKS - 1))
            begin
              next_state = DSS_ON;
              next_btn_latch = 1'b1;
              next_hold_cnt = '0;
            end
          end
          else if (wake_rise)
          begin
            next_state = DSS_ON;
          end
        end
        DSS_ON:
        begin
          if (btn_low && !btn_latch)
          begin
            if (hold_cnt == CNT_W'(SLEEP_TICKS - 1))
            begin
              next_state = DSS_OFF;
              next_btn_latch = 1'b1;
              next_hold_cnt = '0;
            end
          end
          else if (sdr_rise && !wake_rise)
          begin
            next_state = DSS_SHUTDOWN_WAIT;
            next_delay_cnt = '0;
            next_press_seen = 1'b0;
          end
        end
        DSS_SHUTDOWN_WAIT:
        begin
          next_delay_cnt = delay_cnt + 1'b1;
          if (btn_low)
          begin
            next_press_seen = 1'b1;
          end
          if (press_seen && !btn_low)
          begin
            next_state = DSS_ON;
          end
          else if (btn_low && !btn_latch &&
                   hold_cnt == CNT_W'(SLEEP_TICKS - 1))
          begin
            next_state = DSS_OFF;
            next_btn_latch = 1'b1;
            next_hold_cnt = '0;
          end
          else if (!press_seen && !btn_low &&
                   delay_cnt == CNT_W'(SHUTDOWN_TICKS - 1))
          begin
            next_state = DSS_OFF;
          end
        end
        default:
        begin
          next_state = DSS_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state <= DSS_OFF;
      hold_cnt <= '0;
      delay_cnt <= '0;
      wake_d <= 1'b0;
      sdr_armed <= 1'b0;
      btn_latch <= 1'b0;
      press_seen <= 1'b0;
    end
    else
    begin
      state <= next_state;
      hold_cnt <= next_hold_cnt;
      delay_cnt <= next_delay_cnt;
      wake_d <= next_wake_d;
      sdr_armed <= next_sdr_armed;
      btn_latch <= next_btn_latch;
      press_seen <= next_press_seen;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs, registered so the switch and discharge never overlap

  logic next_switch_on;

  always_comb
  begin
    next_switch_on = (next_state != DSS_OFF);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      switch_on_o <= RST_SWITCH_ON;
      discharge_on_o <= RST_DISCHARGE_ON;
      state_o <= DSS_OFF;
    end
    else
    begin
      switch_on_o <= next_switch_on;
      discharge_on_o <= ~next_switch_on;
      state_o <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_off_to_on;
    state == DSS_OFF ##1 state == DSS_ON;
  endsequence

  sequence s_wait_to_off;
    state == DSS_SHUTDOWN_WAIT ##1 state == DSS_OFF;
  endsequence

  // Pins against the state, so a bad output decode cannot hide behind
  // the shared inversion of the two enables
  AST_EXCLUSIVE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    switch_on_o == (state != DSS_OFF) &&
      discharge_on_o == (state == DSS_OFF))
    else $error("switch and discharge disagree");

  // Same cycle: both outputs are registered together with the state
  AST_DISCH_SLEEP: assert property (
    @(posedge clk_i) disable iff (rst_i)
    state == DSS_OFF |-> discharge_on_o && !switch_on_o)
    else $error("discharge off during sleep");

  AST_ON_CAUSE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_off_to_on |-> $past(tick, 1) &&
      ($past(wake_rise, 1) || $past(btn_low, 1)))
    else $error("switch on without cause");

  AST_WAKE_EDGE: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_off_to_on |-> $past(btn_low, 1) || !$past(wake_d, 1))
    else $error("wake level retriggered");

  AST_HOLD_RESTART: assert property (
    @(posedge clk_i) disable iff (rst_i)
    tick && !btn_low |=> hold_cnt == '0)
    else $error("hold count not restarted");

  AST_SDR_REARM: assert property (
    @(posedge clk_i) disable iff (rst_i)
    state == DSS_ON && tick && !sdr_armed |=> state != DSS_SHUTDOWN_WAIT)
    else $error("shutdown request not rearmed");

  AST_SHUTDOWN_TIME: assert property (
    @(posedge clk_i) disable iff (rst_i)
    s_wait_to_off |-> $past(btn_low, 1) ||
      $past(delay_cnt, 1) == CNT_W'(SHUTDOWN_TICKS - 1))
    else $error("shutdown delay wrong");

  AST_CANCEL: assert property (
    @(posedge clk_i) disable iff (rst_i)
    state == DSS_SHUTDOWN_WAIT && tick && press_seen && !btn_low
      |=> state == DSS_ON)
    else $error("shutdown not cancelled");

  AST_NO_EARLY_SLEEP: assert property (
    @(posedge clk_i) disable iff (rst_i)
    state == DSS_ON && tick && btn_low &&
      hold_cnt < CNT_W'(SLEEP_TICKS - 1) |=> state != DSS_OFF)
    else $error("sleep before hold time");

endmodule

/* File: design/dss_pkg.sv */
// Purpose: Shared constants and types for the deep sleep switch control.
// Assumes: 20 MHz system clock, one slow tick per millisecond.
// Notes: Hold and delay times are kept in milliseconds.
package dss_pkg;

  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned TICK_US = 1000;
  // Cycles per slow tick, rounded down so a tick never stretches a hold
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;

  localparam int unsigned TURN_ON_HOLD_MS = 1300;
  localparam int unsigned SLEEP_HOLD_MS = 7000;
  localparam int unsigned SHUTDOWN_DELAY_MS = 7000;

  localparam int unsigned CNT_W = 13;

  localparam logic RST_SWITCH_ON = 1'b0;
  localparam logic RST_DISCHARGE_ON = 1'b1;

  typedef enum logic [1:0] {
    DSS_OFF = 2'b00,
    DSS_ON = 2'b01,
    DSS_SHUTDOWN_WAIT = 2'b10
  } dss_state_t;

endpackage

/* File: design/dss_tick_div.sv */
// Purpose: Divides the system clock into a one-cycle slow tick.
// Assumes: Synchronous active-high reset.
// Notes: The tick drives input sampling and all hold counters.
`timescale 1ns/1ps
module dss_tick_div #(
  parameter int unsigned DIV = 20000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  output logic tick_o
);

  logic [15:0] count;
  logic [15:0] next_count;
  logic next_tick;

  always_comb
  begin
    next_count = count + 16'h0001;
    next_tick = 1'b0;
    if (count == 16'(DIV - 1))
    begin
      next_count = 16'h0000;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count <= 16'h0000;
      tick_o <= 1'b0;
    end
    else
    begin
      count <= next_count;
      tick_o <= next_tick;
    end
  end

endmodule

/* File: testbench/dss_far_side.sv */
// Purpose: Far-side model: push button, charger wake, system controller.
// Assumes: The bench sets the command levels on the falling edge.
// Notes: Idle levels match the pin pull-up and pull-downs.
`timescale 1ns/1ps
module dss_far_side (
  input wire logic clk_i,
  input wire logic btn_level_n_i,
  input wire logic wake_i,
  input wire logic off_req_i,
  output logic hold_button_n_o,
  output logic wake_o,
  output logic shutdown_req_o
);
  // Released button and quiet requests until commanded
  initial
  begin
    hold_button_n_o = 1'h1;
    wake_o = 1'h0;
    shutdown_req_o = 1'h0;
  end
  always @(negedge clk_i)
  begin
    hold_button_n_o <= btn_level_n_i;
    wake_o <= wake_i;
    // Request falls back low before any new edge is offered
    shutdown_req_o <= off_req_i;
  end
endmodule

/* File: testbench/dss_ctrl_tb.sv */
// Purpose: Self-checking bench for the deep sleep switch control.
// Assumes: Short tick and hold counts so the run stays brief.
// Notes: Step table first, then reset and timing-window tests.
`timescale 1ns/1ps
module dss_ctrl_tb;
  import dss_pkg::*;
  localparam int TD = 4;
  localparam int N_ON = 5;
  localparam int N_SLP = 9;
  // Longer than a short press so a cancel never races the delay end
  localparam int N_SD = 12;
  localparam int NR = 25;
  typedef struct {
    logic b, w, s;
    int n;
    logic sw;
    dss_state_t st;
  } dss_row_t;
  dss_row_t rows [NR] = '{
    '{1, 0, 0, 20, 0, DSS_OFF},
    '{0, 0, 0, 12, 0, DSS_OFF},
    '{1, 0, 0, 20, 0, DSS_OFF},
    '{0, 0, 0, 12, 0, DSS_OFF},
    '{1, 0, 0, 20, 0, DSS_OFF},
    '{1, 1, 0, 20, 1, DSS_ON},
    '{1, 1, 1, 16, 1, DSS_SHUTDOWN_WAIT},
    '{1, 1, 1, 56, 0, DSS_OFF},
    '{1, 0, 1, 12, 0, DSS_OFF},
    '{1, 1, 1, 20, 1, DSS_ON},
    '{1, 1, 1, 40, 1, DSS_ON},
    '{1, 1, 0, 12, 1, DSS_ON},
    '{1, 1, 1, 16, 1, DSS_SHUTDOWN_WAIT},
    '{0, 1, 1, 12, 1, DSS_SHUTDOWN_WAIT},
    '{1, 1, 1, 20, 1, DSS_ON},
    '{1, 1, 1, 40, 1, DSS_ON},
    '{0, 1, 1, 60, 0, DSS_OFF},
    '{1, 0, 0, 20, 0, DSS_OFF},
    '{0, 0, 0, 40, 1, DSS_ON},
    '{0, 0, 0, 60, 1, DSS_ON},
    '{1, 0, 0, 20, 1, DSS_ON},
    '{0, 0, 0, 24, 1, DSS_ON},
    '{1, 0, 0, 20, 1, DSS_ON},
    '{0, 0, 0, 60, 0, DSS_OFF},
    '{1, 1, 1, 40, 1, DSS_ON}
  };
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic btn_n = 1'h1;
  logic wk = 1'h0;
  logic sd = 1'h0;
  logic hb_n, wake, sdr, switch_on, discharge_on;
  dss_state_t state;
  int fail_count = 0;
  int total_checks = 0;
  int i;

  always #25 clk_i = ~clk_i;

  dss_far_side far (.clk_i(clk_i), .btn_level_n_i(btn_n), .wake_i(wk),
    .off_req_i(sd), .hold_button_n_o(hb_n), .wake_o(wake),
    .shutdown_req_o(sdr));

  dss_ctrl #(.TICK_DIV(TD), .TURN_ON_TICKS(N_ON), .SLEEP_TICKS(N_SLP),
    .SHUTDOWN_TICKS(N_SD)) dut (.clk_i(clk_i), .rst_i(rst_i),
    .hold_button_n_i(hb_n), .wake_i(wake), .shutdown_req_i(sdr),
    .switch_on_o(switch_on), .discharge_on_o(discharge_on),
    .state_o(state));

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_state(input dss_state_t got, input dss_state_t exp);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic chk_time(input int got, input int lo, input int hi);
    total_checks++;
    if (got < lo || got > hi)
    begin
      fail_count++;
      $display("wrong value at %0t: got %0h expected %0h..%0h", $time, got,
        lo, hi);
    end
  endtask

  task automatic check_outs(input logic sw, input dss_state_t st);
    chk_bit(switch_on, sw);
    chk_bit(discharge_on, ~sw);
    chk_state(state, st);
  endtask

  task automatic drive(input logic b, input logic w, input logic s,
    input int n);
    @(negedge clk_i);
    btn_n <= b;
    wk <= w;
    sd <= s;
    repeat (n - 1) @(negedge clk_i);
  endtask

  // Counts cycles to a state; running out of the bound ends the run
  task automatic wait_st(input dss_state_t st, input int lo, input int hi);
    int n;
    n = 0;
    while (state !== st && n <= hi)
    begin
      @(negedge clk_i);
      n++;
    end
    if (n > hi)
    begin
      fail_count++;
      wrap_up();
    end
    else
      chk_time(n, lo, hi);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(negedge clk_i);
    check_outs(1'h0, DSS_OFF);
    rst_i = 1'h0;
    for (i = 0; i < NR; i++)
    begin
      drive(rows[i].b, rows[i].w, rows[i].s, rows[i].n);
      check_outs(rows[i].sw, rows[i].st);
    end
    // Reset in mid-run while the switch is on
    rst_i = 1'h1;
    drive(1'h1, 1'h0, 1'h0, 2);
    check_outs(1'h0, DSS_OFF);
    rst_i = 1'h0;
    drive(1'h1, 1'h0, 1'h0, 8);
    check_outs(1'h0, DSS_OFF);
    drive(1'h0, 1'h0, 1'h0, 1);
    wait_st(DSS_ON, (N_ON - 1) * TD, (N_ON + 4) * TD);
    check_outs(1'h1, DSS_ON);
    drive(1'h1, 1'h0, 1'h0, 12);
    drive(1'h1, 1'h0, 1'h1, 1);
    wait_st(DSS_SHUTDOWN_WAIT, 0, 4 * TD);
    wait_st(DSS_OFF, (N_SD - 1) * TD, (N_SD + 2) * TD);
    check_outs(1'h0, DSS_OFF);
    drive(1'h1, 1'h1, 1'h1, 1);
    wait_st(DSS_ON, 0, 4 * TD);
    drive(1'h0, 1'h1, 1'h1, 1);
    wait_st(DSS_OFF, (N_SLP - 1) * TD, (N_SLP + 4) * TD);
    check_outs(1'h0, DSS_OFF);
    // Button press and wake edge reach the same tick: the press wins,
    // so the switch must still be off before the hold time is up
    drive(1'h1, 1'h0, 1'h0, 12);
    drive(1'h0, 1'h1, 1'h0, 20);
    check_outs(1'h0, DSS_OFF);
    wait_st(DSS_ON, 0, 4 * TD);
    // Press and shutdown edge together while on: no shutdown delay,
    // the press alone runs on into sleep
    drive(1'h1, 1'h1, 1'h0, 12);
    drive(1'h0, 1'h1, 1'h1, 20);
    check_outs(1'h1, DSS_ON);
    wait_st(DSS_OFF, 4 * TD, 8 * TD);
    check_outs(1'h0, DSS_OFF);
    wrap_up();
  end
endmodule
